// ==== hdl/phy_mii_pins.sv ====
// MAC-facing pin logic of a 10/100 transceiver: MII, serial mode, straps.
// Assumes pins arrive unsynchronised; line side is on the same clock.
//
// Operation
// - 100M transmit error sends HALT; 10M ignores
// - Serial mode: only transmit bit 0 used
// - Transmit clock rate follows speed and mode
// - Transmit clock pin strap loads detach bit
// - Management data line shared, released when idle
// - Receive nibbles synchronous to own receive clock
// - Serial mode: receive data on bit 0
// - Address strap from receive data and carrier
// - Open-drain interrupt low on status change
// - Receive clock generated here, times receive outputs
// - Half duplex carrier on receive or transmit
// - Half duplex collision output while colliding
// - Data valid exactly while receive data valid
// - Receive error strap latched as repeater select, read back only
// - Receive outputs released when enable is low
// - Reset initialises all logic
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module phy_mii_pins (
    // System
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // MAC transmit
    input wire logic [3:0] tx_data,
    input wire logic tx_en,
    input wire logic tx_er,
    input wire logic tx_clk_in,
    output logic tx_clk_out,
    output logic tx_clk_oe,
    // MAC receive
    input wire logic receive_output_enable,
    input wire logic [3:0] rx_data_in,
    input wire logic rx_er_in,
    input wire logic crs_in,
    output logic rx_clk_out,
    output logic [3:0] rx_data_out,
    output logic rx_dv_out,
    output logic rx_oe,
    output logic rx_er_out,
    output logic crs_out,
    output logic col_out,
    output logic status_oe,
    // Management
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    output logic status_change_irq_n,
    output logic irq_oe,
    // Line side
    input wire logic [3:0] line_rx_data,
    input wire logic line_rx_valid,
    input wire logic line_rx_error,
    input wire logic line_rx_active,
    output logic [4:0] line_tx_code,
    output logic line_tx_valid
);
    phy_mii_pkg::pins_type sync1_reg, s;
    phy_mii_pkg::ctrl_type ctrl_reg;
    phy_mii_pkg::mdio_state_type md_state_reg;
    logic [7:0] div_reg, half;
    logic clk_reg, tick, tx_sample, rx_update;
    logic [1:0] strap_cnt_reg;
    logic strap_done_reg;
    logic [4:0] management_address_strap;
    logic repeater_select_strap, detach_reg;
    logic [2:0] stat_prev_reg;
    logic mdc_prev_reg, mdc_rise;
    logic [5:0] ones_reg;
    logic [4:0] bits_reg;
    logic [12:0] hdr_reg;
    logic [15:0] shift_reg;
    logic rd_reg, mgmt_wr_reg, stat_read_reg;
    logic [15:0] mgmt_wdata_reg;

    function automatic logic [15:0] mii_read(input logic [4:0] r);
        mii_read = 16'h0000;
        if (r == phy_mii_pkg::MII_CTRL_REG)
        begin
            mii_read[phy_mii_pkg::DETACH_BIT] = detach_reg;
            mii_read[phy_mii_pkg::SPEED_BIT] = ctrl_reg.speed_100;
            mii_read[phy_mii_pkg::DUPLEX_BIT] = ctrl_reg.full_duplex;
        end
        else if (r == phy_mii_pkg::MII_STAT_REG)
            mii_read[phy_mii_pkg::LINK_BIT] = ctrl_reg.link_up;
    endfunction : mii_read

    // -----------------------------------------------------------------
    // Pin synchronisers and reset
    // -----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sync1_reg <= '0;
            s <= '0;
        end
        else
        begin
            sync1_reg <= {tx_clk_in, crs_in, rx_er_in, rx_data_in,
                          receive_output_enable, mdio_in, mdc, tx_er,
                          tx_en, tx_data};
            s <= sync1_reg;
        end
    end

    // -----------------------------------------------------------------
    // Straps
    // -----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            strap_cnt_reg <= 2'h0;
            strap_done_reg <= 1'b0;
            management_address_strap <= 5'h00;
            repeater_select_strap <= 1'b0;
        end
        else if (!strap_done_reg)
        begin
            strap_cnt_reg <= strap_cnt_reg + 2'h1;
            if (strap_cnt_reg == phy_mii_pkg::STRAP_WAIT - 2'h1)
            begin
                strap_done_reg <= 1'b1;
                management_address_strap <= {s.crs_strap,
                                             s.rx_data_strap};
                repeater_select_strap <= s.rx_er_strap;
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            detach_reg <= 1'b0;
        else if (!strap_done_reg &&
                 strap_cnt_reg == phy_mii_pkg::STRAP_WAIT - 2'h1)
            detach_reg <= s.tx_clk_strap;
        else if (mgmt_wr_reg)
            detach_reg <= mgmt_wdata_reg[phy_mii_pkg::DETACH_BIT];
    end

    // -----------------------------------------------------------------
    // Register port
    // -----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_reg <= phy_mii_pkg::CTRL_RESET;
            reg_rdata <= 32'h0000_0000;
        end
        else
        begin
            if (reg_write && reg_addr == phy_mii_pkg::CTRL_ADDR)
                ctrl_reg <= reg_wdata[4:0];
            reg_rdata <= 32'h0000_0000;
            if (reg_read && reg_addr == phy_mii_pkg::CTRL_ADDR)
                reg_rdata <= {27'h0, ctrl_reg};
            else if (reg_read && reg_addr == phy_mii_pkg::STAT_ADDR)
                reg_rdata <= {22'h0, irq_oe, col_out, crs_out, detach_reg,
                              repeater_select_strap,
                              management_address_strap};
        end
    end

    // -----------------------------------------------------------------
    // Transmit and receive clock divider
    // -----------------------------------------------------------------
    assign half = ctrl_reg.seven_wire_serial_mode ? phy_mii_pkg::HALF_SER :
                  ctrl_reg.speed_100 ? phy_mii_pkg::HALF_100 :
                  phy_mii_pkg::HALF_10;
    assign tick = (div_reg >= half - 8'h01);
    assign tx_sample = tick && clk_reg;
    assign rx_update = tick && !clk_reg;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            div_reg <= 8'h00;
            clk_reg <= 1'b0;
            tx_clk_out <= 1'b0;
            rx_clk_out <= 1'b0;
        end
        else
        begin
            div_reg <= tick ? 8'h00 : div_reg + 8'h01;
            if (tick)
                clk_reg <= !clk_reg;
            tx_clk_out <= clk_reg;
            rx_clk_out <= clk_reg;
        end
    end

    // -----------------------------------------------------------------
    // Transmit path
    // -----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            line_tx_code <= 5'h00;
            line_tx_valid <= 1'b0;
        end
        else if (tx_sample)
        begin
            line_tx_valid <= s.tx_en;
            if (ctrl_reg.seven_wire_serial_mode)
                line_tx_code <= {4'h0, s.tx_data[0]};
            else if (ctrl_reg.encoder_bypass)
                line_tx_code <= {s.tx_er, s.tx_data};
            else if (ctrl_reg.speed_100 && s.tx_er && s.tx_en)
                line_tx_code <= phy_mii_pkg::HALT_CODE;
            else
                line_tx_code <= phy_mii_pkg::encode_4b5b(s.tx_data);
        end
    end

    // -----------------------------------------------------------------
    // Receive path and indications
    // -----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rx_data_out <= 4'h0;
            rx_dv_out <= 1'b0;
            rx_er_out <= 1'b0;
        end
        else if (rx_update)
        begin
            if (ctrl_reg.seven_wire_serial_mode)
                rx_data_out <= {3'h0, line_rx_data[0]};
            else
                rx_data_out <= line_rx_data;
            rx_dv_out <= line_rx_valid;
            rx_er_out <= line_rx_error &&
                         !ctrl_reg.seven_wire_serial_mode;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            crs_out <= 1'b0;
            col_out <= 1'b0;
            rx_oe <= 1'b0;
            tx_clk_oe <= 1'b0;
            status_oe <= 1'b0;
        end
        else
        begin
            crs_out <= line_rx_active ||
                       (s.tx_en && !ctrl_reg.full_duplex);
            col_out <= !ctrl_reg.full_duplex && s.tx_en &&
                       line_rx_active;
            rx_oe <= strap_done_reg && s.receive_output_enable;
            tx_clk_oe <= strap_done_reg;
            status_oe <= strap_done_reg;
        end
    end

    // -----------------------------------------------------------------
    // Status change interrupt
    // -----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            stat_prev_reg <= 3'h0;
            irq_oe <= 1'b0;
            status_change_irq_n <= 1'b0;
        end
        else
        begin
            stat_prev_reg <= {ctrl_reg.link_up, ctrl_reg.speed_100,
                              ctrl_reg.full_duplex};
            if (stat_prev_reg != {ctrl_reg.link_up, ctrl_reg.speed_100,
                                  ctrl_reg.full_duplex})
                irq_oe <= 1'b1;
            else if (stat_read_reg)
                irq_oe <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // Management frame engine
    // -----------------------------------------------------------------
    assign mdc_rise = s.mdc && !mdc_prev_reg;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mdc_prev_reg <= 1'b0;
            md_state_reg <= phy_mii_pkg::MD_PREAMBLE;
            ones_reg <= 6'h00;
            bits_reg <= 5'h00;
            hdr_reg <= 13'h0000;
            shift_reg <= 16'h0000;
            rd_reg <= 1'b0;
            mdio_out <= 1'b0;
            mdio_oe <= 1'b0;
            mgmt_wr_reg <= 1'b0;
            mgmt_wdata_reg <= 16'h0000;
            stat_read_reg <= 1'b0;
        end
        else
        begin
            mdc_prev_reg <= s.mdc;
            mgmt_wr_reg <= 1'b0;
            stat_read_reg <= 1'b0;
            if (mdc_rise)
            begin
                case (md_state_reg)
                    phy_mii_pkg::MD_PREAMBLE:
                    begin
                        bits_reg <= 5'h00;
                        if (s.mdio)
                            ones_reg <= (ones_reg < phy_mii_pkg::PREAMBLE_ONES)
                                        ? ones_reg + 6'h01 : ones_reg;
                        else
                        begin
                            ones_reg <= 6'h00;
                            if (ones_reg == phy_mii_pkg::PREAMBLE_ONES)
                                md_state_reg <= phy_mii_pkg::MD_HEADER;
                        end
                    end
                    phy_mii_pkg::MD_HEADER:
                    begin
                        hdr_reg <= {hdr_reg[11:0], s.mdio};
                        bits_reg <= bits_reg + 5'h01;
                        if (bits_reg == phy_mii_pkg::HDR_LAST)
                        begin
                            bits_reg <= 5'h00;
                            md_state_reg <= phy_mii_pkg::MD_TURN;
                        end
                    end
                    phy_mii_pkg::MD_TURN:
                    begin
                        bits_reg <= bits_reg + 5'h01;
                        if (bits_reg == 5'h00)
                        begin
                            rd_reg <= hdr_reg[11:10] == phy_mii_pkg::OP_READ;
                            if (!hdr_reg[12] || hdr_reg[9:5] !=
                                management_address_strap)
                                md_state_reg <= phy_mii_pkg::MD_PREAMBLE;
                            else if (hdr_reg[11:10] == phy_mii_pkg::OP_READ)
                            begin
                                mdio_oe <= 1'b1;
                                mdio_out <= 1'b0;
                                shift_reg <= mii_read(hdr_reg[4:0]);
                                stat_read_reg <= hdr_reg[4:0] ==
                                                 phy_mii_pkg::MII_STAT_REG;
                            end
                            else if (hdr_reg[11:10] != phy_mii_pkg::OP_WRITE)
                                md_state_reg <= phy_mii_pkg::MD_PREAMBLE;
                        end
                        else
                        begin
                            bits_reg <= 5'h00;
                            md_state_reg <= phy_mii_pkg::MD_DATA;
                            if (rd_reg)
                            begin
                                mdio_out <= shift_reg[15];
                                shift_reg <= {shift_reg[14:0], 1'b0};
                            end
                        end
                    end
                    phy_mii_pkg::MD_DATA:
                    begin
                        bits_reg <= bits_reg + 5'h01;
                        mdio_out <= shift_reg[15];
                        shift_reg <= {shift_reg[14:0], s.mdio};
                        if (bits_reg == phy_mii_pkg::DATA_LAST)
                        begin
                            mdio_oe <= 1'b0;
                            mdio_out <= 1'b0;
                            md_state_reg <= phy_mii_pkg::MD_PREAMBLE;
                            mgmt_wr_reg <= !rd_reg && hdr_reg[4:0] ==
                                           phy_mii_pkg::MII_CTRL_REG;
                            mgmt_wdata_reg <= {shift_reg[14:0], s.mdio};
                        end
                    end
                    default: md_state_reg <= phy_mii_pkg::MD_PREAMBLE;
                endcase
            end
        end
    end

    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_halt_subst: assert property (tx_sample && ctrl_reg.speed_100 &&
        !ctrl_reg.encoder_bypass && !ctrl_reg.seven_wire_serial_mode &&
        s.tx_er && s.tx_en |=> line_tx_code == phy_mii_pkg::HALT_CODE)
        else $error("HALT not sent on transmit error");
    a_bypass_fifth: assert property (tx_sample && ctrl_reg.encoder_bypass &&
        !ctrl_reg.seven_wire_serial_mode |=>
        line_tx_code == $past({s.tx_er, s.tx_data}))
        else $error("Bypass code group wrong");
    a_serial_bit: assert property (tx_sample &&
        ctrl_reg.seven_wire_serial_mode |=>
        line_tx_code == {4'h0, $past(s.tx_data[0])})
        else $error("Serial transmit bit wrong");
    a_detach_strap: assert property ($rose(strap_done_reg) |->
        detach_reg == $past(s.tx_clk_strap))
        else $error("Detach strap not latched");
    a_addr_strap: assert property ($rose(strap_done_reg) |->
        management_address_strap ==
        $past({s.crs_strap, s.rx_data_strap}))
        else $error("Address strap not latched");
    a_irq_change: assert property ($changed({ctrl_reg.link_up,
        ctrl_reg.speed_100, ctrl_reg.full_duplex}) |-> ##2 irq_oe)
        else $error("Interrupt not raised on status change");
    a_rx_release: assert property (!s.receive_output_enable |=> !rx_oe)
        else $error("Receive outputs not released");
    a_col_fdx: assert property ($past(ctrl_reg.full_duplex) |-> !col_out)
        else $error("Collision in full duplex");
    a_dv_follow: assert property (rx_update |=>
        rx_dv_out == $past(line_rx_valid))
        else $error("Data valid does not follow line");
    a_mdio_own: assert property (mdio_oe |->
        rd_reg && (md_state_reg != phy_mii_pkg::MD_PREAMBLE))
        else $error("Management line driven outside read");
endmodule : phy_mii_pins

// ==== inc/phy_mii_pkg.sv ====
// Constants, carriers and helpers for the MII pin interface block.
// Assumes a 25 MHz system clock sampling every MAC-side pin through two flops.
package phy_mii_pkg;
    // -----------------------------------------------------------------
    // Timing
    // -----------------------------------------------------------------
    localparam int CLK_NS = 40;
    localparam int TXCLK_100_NS = 40;
    localparam int TXCLK_10_NS = 400;
    localparam int TXCLK_SER_NS = 100;
    localparam int H100 = (TXCLK_100_NS / 2) / CLK_NS;
    localparam int H10 = (TXCLK_10_NS / 2) / CLK_NS;
    localparam int HSER = (TXCLK_SER_NS / 2) / CLK_NS;
    localparam logic [7:0] HALF_100 = 8'((H100 < 1) ? 1 : H100);
    localparam logic [7:0] HALF_10 = 8'((H10 < 1) ? 1 : H10);
    localparam logic [7:0] HALF_SER = 8'((HSER < 1) ? 1 : HSER);
    localparam logic [1:0] STRAP_WAIT = 2'h3;
    // -----------------------------------------------------------------
    // Register port
    // -----------------------------------------------------------------
    localparam logic [3:0] CTRL_ADDR = 4'h0;
    localparam logic [3:0] STAT_ADDR = 4'h4;
    localparam logic [4:0] CTRL_RESET = 5'h01;
    localparam logic [4:0] HALT_CODE = 5'h04;
    // -----------------------------------------------------------------
    // Management frame
    // -----------------------------------------------------------------
    localparam logic [5:0] PREAMBLE_ONES = 6'h20;
    localparam logic [4:0] HDR_LAST = 5'h0c;
    localparam logic [4:0] DATA_LAST = 5'h0f;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [4:0] MII_CTRL_REG = 5'h00;
    localparam logic [4:0] MII_STAT_REG = 5'h01;
    localparam int DETACH_BIT = 10;
    localparam int SPEED_BIT = 13;
    localparam int DUPLEX_BIT = 8;
    localparam int LINK_BIT = 2;

    typedef struct packed {
        logic link_up;
        logic encoder_bypass;
        logic seven_wire_serial_mode;
        logic full_duplex;
        logic speed_100;
    } ctrl_type;

    typedef struct packed {
        logic tx_clk_strap;
        logic crs_strap;
        logic rx_er_strap;
        logic [3:0] rx_data_strap;
        logic receive_output_enable;
        logic mdio;
        logic mdc;
        logic tx_er;
        logic tx_en;
        logic [3:0] tx_data;
    } pins_type;

    typedef enum logic [3:0] {
        MD_PREAMBLE = 4'h1,
        MD_HEADER = 4'h2,
        MD_TURN = 4'h4,
        MD_DATA = 4'h8
    } mdio_state_type;

    function automatic logic [4:0] encode_4b5b(input logic [3:0] n);
        case (n)
            4'h0: encode_4b5b = 5'h1e;
            4'h1: encode_4b5b = 5'h09;
            4'h2: encode_4b5b = 5'h14;
            4'h3: encode_4b5b = 5'h15;
            4'h4: encode_4b5b = 5'h0a;
            4'h5: encode_4b5b = 5'h0b;
            4'h6: encode_4b5b = 5'h0e;
            4'h7: encode_4b5b = 5'h0f;
            4'h8: encode_4b5b = 5'h12;
            4'h9: encode_4b5b = 5'h13;
            4'ha: encode_4b5b = 5'h16;
            4'hb: encode_4b5b = 5'h17;
            4'hc: encode_4b5b = 5'h1a;
            4'hd: encode_4b5b = 5'h1b;
            4'he: encode_4b5b = 5'h1c;
            default: encode_4b5b = 5'h1d;
        endcase
    endfunction : encode_4b5b
endpackage : phy_mii_pkg

// ==== bench/mac_model.sv ====
// Behavioural MAC and management station facing the MII pins.
// Assumes the bench sets the next nibble; pins move on tx clock rise.
`timescale 1ns/1ps
module mac_model (
    // System
    input wire logic clk,
    // Bench side
    input wire logic [3:0] next_data,
    input wire logic next_en,
    input wire logic next_er,
    // Pins
    input wire logic tx_clk_out,
    input wire logic mdio_out,
    input wire logic mdio_oe,
    input wire logic sta_mdio,
    output logic [3:0] tx_data,
    output logic tx_en,
    output logic tx_er,
    output logic mdio_in
);
    logic tx_clk_reg;
    initial
    begin
        tx_clk_reg = 1'b0;
        tx_data = 4'h0;
        tx_en = 1'b0;
        tx_er = 1'b0;
    end
    // Station drives the line while the block has released it
    assign mdio_in = mdio_oe ? mdio_out : sta_mdio;
    // Change pins only just after a rising tx clock
    always @(posedge clk)
    begin
        tx_clk_reg <= tx_clk_out;
        if (tx_clk_out && !tx_clk_reg)
        begin
            tx_data <= next_data;
            tx_en <= next_en;
            tx_er <= next_er;
        end
    end
endmodule : mac_model

// ==== bench/phy_mii_pins_tb.sv ====
// Self-checking bench for the MII pin block.
// Assumes the package and design are compiled first.
`timescale 1ns/1ps
module phy_mii_pins_tb;
    logic clk, rst, reg_write, reg_read, tx_en, tx_er, tx_clk_in, roe;
    logic [3:0] reg_addr, tx_data, rx_data_in, line_rx_data, rx_data_out;
    logic [31:0] reg_wdata, reg_rdata, rdv;
    logic rx_er_in, crs_in, tx_clk_out, tx_clk_oe, rx_clk_out, rx_dv_out;
    logic rx_oe, rx_er_out, crs_out, col_out, status_oe, mdc, mdio_in;
    logic mdio_out, mdio_oe, irq_n, irq_oe, line_rx_valid, line_rx_error;
    logic line_rx_active, line_tx_valid, next_en, next_er, sta_mdio;
    logic [15:0] mv;
    logic [4:0] line_tx_code;
    logic [3:0] next_data;
    int failures, total_checks;
    phy_mii_pins i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .tx_data(tx_data), .tx_en(tx_en),
        .tx_er(tx_er), .tx_clk_in(tx_clk_in), .tx_clk_out(tx_clk_out),
        .tx_clk_oe(tx_clk_oe), .receive_output_enable(roe),
        .rx_data_in(rx_data_in), .rx_er_in(rx_er_in), .crs_in(crs_in),
        .rx_clk_out(rx_clk_out), .rx_data_out(rx_data_out),
        .rx_dv_out(rx_dv_out), .rx_oe(rx_oe), .rx_er_out(rx_er_out),
        .crs_out(crs_out), .col_out(col_out), .status_oe(status_oe),
        .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
        .mdio_oe(mdio_oe), .status_change_irq_n(irq_n), .irq_oe(irq_oe),
        .line_rx_data(line_rx_data), .line_rx_valid(line_rx_valid),
        .line_rx_error(line_rx_error), .line_rx_active(line_rx_active),
        .line_tx_code(line_tx_code), .line_tx_valid(line_tx_valid));
    mac_model i_mac (.clk(clk), .next_data(next_data), .next_en(next_en),
        .next_er(next_er), .tx_clk_out(tx_clk_out), .mdio_out(mdio_out),
        .mdio_oe(mdio_oe), .sta_mdio(sta_mdio), .tx_data(tx_data),
        .tx_en(tx_en),
        .tx_er(tx_er), .mdio_in(mdio_in));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 rdv = reg_rdata;
    endtask : rd
    task automatic send(input logic [3:0] d, input logic e, input logic r);
        next_data <= d;
        next_en <= e;
        next_er <= r;
        repeat (30) @(posedge clk);
        #1;
    endtask : send
    task automatic mgmt_bit(input logic b, output logic q);
        sta_mdio <= b;
        mdc <= 1'b0;
        repeat (5) @(posedge clk);
        q = mdio_in;
        mdc <= 1'b1;
        repeat (5) @(posedge clk);
    endtask : mgmt_bit
    task automatic mgmt_read(input logic [4:0] r, output logic [15:0] v);
        logic q;
        logic [47:0] f;
        f = {32'hffff_ffff, 4'h6, 5'h1a, r, 2'h3};
        for (int i = 47; i >= 0; i--)
            mgmt_bit(f[i], q);
        for (int i = 15; i >= 0; i--)
        begin
            mgmt_bit(1'b1, q);
            v[i] = q;
        end
        mgmt_bit(1'b1, q);
    endtask : mgmt_read
    task automatic finish_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test
    // ------------------------------------------------------------
    // Clock, watchdog and tests
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial
    begin
        #400000;
        failures++;
        finish_test();
    end
    initial
    begin
        {rst, reg_write, reg_read, roe, tx_clk_in, rx_er_in, crs_in} = 7'h7f;
        {reg_addr, reg_wdata, rx_data_in, line_rx_data} = 44'h0;
        {line_rx_valid, line_rx_error, line_rx_active, mdc} = 4'h0;
        sta_mdio = 1'b1;
        {next_data, next_en, next_er} = 6'h0;
        {reg_write, reg_read, rx_data_in} = {2'h0, 4'ha};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
        rd(phy_mii_pkg::STAT_ADDR);
        chk(rdv[4:0], 5'h1a);
        chk(rdv[5], 1'b1);
        chk(rdv[6], 1'b1);
        rd(phy_mii_pkg::CTRL_ADDR);
        chk(rdv[4:0], 5'h01);
        rd(4'h8);
        chk(rdv, 32'h0);
        chk(mdio_oe, 1'b0);
        $display("test straps done");
        send(4'h5, 1'b1, 1'b0);
        chk(line_tx_code, 5'h0b);
        send(4'h5, 1'b1, 1'b1);
        chk(line_tx_code, 5'h04);
        wr(phy_mii_pkg::CTRL_ADDR, 32'h0);
        repeat (4) @(posedge clk);
        #1 chk(irq_oe, 1'b1);
        send(4'h5, 1'b1, 1'b1);
        chk(line_tx_code, 5'h0b);
        wr(phy_mii_pkg::CTRL_ADDR, 32'h9);
        send(4'h3, 1'b1, 1'b1);
        chk(line_tx_code, 5'h13);
        wr(phy_mii_pkg::CTRL_ADDR, 32'h4);
        send(4'he, 1'b1, 1'b0);
        chk(line_tx_code, 5'h00);
        send(4'hf, 1'b1, 1'b0);
        chk(line_tx_code, 5'h01);
        $display("test transmit done");
        line_rx_data <= 4'h6;
        line_rx_valid <= 1'b1;
        send(4'h0, 1'b0, 1'b0);
        chk(rx_data_out, 4'h0);
        wr(phy_mii_pkg::CTRL_ADDR, 32'h1);
        line_rx_data <= 4'h7;
        line_rx_active <= 1'b1;
        send(4'h1, 1'b1, 1'b0);
        chk(rx_data_out, 4'h7);
        chk(rx_dv_out, 1'b1);
        chk(crs_out, 1'b1);
        chk(col_out, 1'b1);
        chk(rx_oe, 1'b1);
        line_rx_valid <= 1'b0;
        roe <= 1'b0;
        send(4'h0, 1'b0, 1'b0);
        chk(rx_dv_out, 1'b0);
        chk(rx_oe, 1'b0);
        chk(col_out, 1'b0);
        $display("test receive done");
        mgmt_read(5'h00, mv);
        chk(mv, 16'h2400);
        chk(mdio_oe, 1'b0);
        $display("test management done");
        finish_test();
    end
endmodule : phy_mii_pins_tb
